//--- uet_consts.svh
`ifndef UET_CONSTS_SVH
`define UET_CONSTS_SVH
`define UET_OVERSAMPLE      16
`define UET_DIV_RESET       16'h000D
`define UET_TX_START_MIN    8
`define UET_TX_START_MAX    24
`define UET_TX_START_WAIT   12
`define UET_DATA_BITS       8
`define UET_STAT_DR_BIT     0
`define UET_IIR_RX_CODE     4'h4
`define UET_IIR_TX_CODE     4'h2
`define UET_IIR_NONE_CODE   4'h1
`endif

//--- uet_pkg.sv
package uet_pkg;
    typedef struct packed {
        logic       rd_rx;
        logic       wr_tx;
        logic [7:0] wdata;
    } uet_host_req_t;
    typedef struct packed {
        logic [7:0] receive_holding_word;
        logic [7:0] line_status_word;
        logic [3:0] interrupt_source_word;
    } uet_host_view_t;
    typedef enum logic [1:0] {
        UET_RX_IDLE, UET_RX_SHIFT, UET_RX_LOAD
    } uet_rx_state_t;
endpackage

//--- uet_baud_gen.sv
`timescale 1ns/100ps
`include "uet_consts.svh"
module uet_baud_gen
    import uet_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic [DIV_W-1:0] divisor,
    output logic                  tick16
);
    logic [DIV_W-1:0] count;
    // A one-bit counter cannot divide; refuse at elaboration
    if (DIV_W < 2) begin
        $error("DIV_W too small");
    end
    // [RQ3] one tick per 1/16 bit
    always_ff @(posedge clk) begin
        if (srst) begin
            count  <= '0;
            tick16 <= 1'b0;
        end else if (count + 1'b1 >= divisor || divisor == '0) begin
            count  <= '0;
            tick16 <= 1'b1;
        end else begin
            count  <= count + 1'b1;
            tick16 <= 1'b0;
        end
    end
endmodule

//--- uet_channel.sv
// Behaviour
// [RQ1] Non-FIFO status may precede holding word
// [RQ2] Holding word valid within one baud tick
// [RQ3] Baud clock is sixteen times bit rate
// [RQ4] FIFO mode data valid with status
// [RQ5] Host waits one baud tick before reading
// [RQ6] Receive interrupt within one baud period
// [RQ7] Transmit starts 8..24 baud periods later; the code waits 12 bit periods (16 ticks each) after the first write
// [RQ8] Receive ready within one clock
// [RQ9] Transmit ready drops within 16 ticks
// [RQ10] Holding read clears interrupt and ready
`timescale 1ns/100ps
`include "uet_consts.svh"
module uet_channel
    import uet_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic [DIV_W-1:0] divisor,
    input  wire logic             fifo_mode,
    input  wire uet_host_req_t    host_req,
    input  wire logic             rx_line,
    output uet_host_view_t        host_view,
    output logic                  irq,
    output logic                  receive_ready_output,
    output logic                  transmit_ready_output,
    output logic                  tx_line
);
    localparam int OS = `UET_OVERSAMPLE;
    // Refused at elaboration rather than at run time
    if (DIV_W > 24) begin
        $error("DIV_W too large");
    end
    logic          tick;
    uet_rx_state_t rx_state;
    logic [3:0]    rx_sub;
    logic [3:0]    rx_bit;
    logic [7:0]    rx_shift;
    logic [7:0]    rx_pend;
    logic          data_ready;
    logic          rx_int;
    logic          tx_int;
    logic          tx_int_first;
    logic          tx_hold_full;
    logic [7:0]    tx_hold;
    logic [4:0]    tx_wait;
    logic          tx_busy;
    logic [3:0]    tx_sub;
    logic [3:0]    tx_bit;
    logic [9:0]    tx_frame;
    logic          stop_done;

    uet_baud_gen #(.DIV_W(DIV_W)) u_baud (
        .clk     (clk),
        .srst    (srst),
        .divisor (divisor),
        .tick16  (tick)
    );

    assign stop_done = tick && rx_state == UET_RX_SHIFT
                       && rx_bit == 4'd9 && rx_sub == 4'(OS - 1) && rx_line;

    // Receiver: samples at mid-bit, checks stop bit
    always_ff @(posedge clk) begin
        if (srst) begin
            rx_state <= UET_RX_IDLE;
            rx_sub   <= '0;
            rx_bit   <= '0;
            rx_shift <= '0;
        end else if (tick) begin
            case (rx_state)
                UET_RX_IDLE: begin
                    if (!rx_line) begin
                        rx_state <= UET_RX_SHIFT;
                        rx_sub   <= '0;
                        rx_bit   <= '0;
                    end
                end
                UET_RX_SHIFT: begin
                    rx_sub <= rx_sub + 4'd1;
                    if (rx_sub == 4'(OS/2 - 1) && rx_bit == 4'd0
                        && rx_line) begin
                        rx_state <= UET_RX_IDLE; // False start
                    end
                    if (rx_sub == 4'(OS/2 - 1) && rx_bit >= 4'd1
                        && rx_bit <= 4'd8) begin
                        rx_shift <= {rx_line, rx_shift[7:1]};
                    end
                    if (rx_sub == 4'(OS - 1)) begin
                        rx_bit <= rx_bit + 4'd1;
                        if (rx_bit == 4'd9) begin
                            rx_state <= rx_line ? UET_RX_LOAD : UET_RX_IDLE;
                        end
                    end
                end
                UET_RX_LOAD: rx_state <= UET_RX_IDLE;
                default: rx_state <= UET_RX_IDLE;
            endcase
        end
    end

    // Status first; word loads one baud tick later when not in FIFO mode
    always_ff @(posedge clk) begin
        if (srst) begin
            rx_pend <= '0;
            host_view.receive_holding_word <= '0;
        end else if (stop_done) begin
            rx_pend <= rx_shift;
            if (fifo_mode) begin
                host_view.receive_holding_word <= rx_shift; // [RQ4]
            end
        end else if (tick && rx_state == UET_RX_LOAD && !fifo_mode) begin
            host_view.receive_holding_word <= rx_pend; // [RQ1] [RQ2]
        end
    end

    // Set wins over the host read in the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            data_ready           <= 1'b0;
            rx_int               <= 1'b0;
            receive_ready_output <= 1'b0;
        end else if (stop_done) begin
            data_ready           <= 1'b1;
            rx_int               <= 1'b1; // [RQ6]
            receive_ready_output <= 1'b1; // [RQ8]
        end else if (host_req.rd_rx) begin
            data_ready           <= 1'b0; // [RQ10]
            rx_int               <= 1'b0;
            receive_ready_output <= 1'b0;
        end
    end

    // Transmit holding, first-clear start delay
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_hold      <= '0;
            tx_hold_full <= 1'b0;
            tx_int       <= 1'b1;
            tx_int_first <= 1'b1;
            tx_wait      <= '0;
        end else if (host_req.wr_tx && !tx_hold_full) begin
            tx_hold      <= host_req.wdata;
            tx_hold_full <= 1'b1;
            tx_int       <= 1'b0;
            if (tx_int_first) begin
                tx_wait <= 5'(`UET_TX_START_WAIT); // [RQ7]
            end
            tx_int_first <= 1'b0;
        end else if (tick && tx_wait != '0 && tx_sub == 4'(OS - 1)) begin
            tx_wait <= tx_wait - 5'd1;
        end else if (tx_hold_full && !tx_busy && tx_wait == '0) begin
            tx_hold_full <= 1'b0;
            tx_int       <= 1'b1;
        end
    end

    // Shifter: start, 8 data, stop; 16 ticks per bit
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_busy  <= 1'b0;
            tx_sub   <= '0;
            tx_bit   <= '0;
            tx_frame <= '1;
            tx_line  <= 1'b1;
        end else if (!tx_busy && tx_hold_full && tx_wait == '0) begin
            tx_busy  <= 1'b1;
            tx_frame <= {1'b1, tx_hold, 1'b0};
            tx_sub   <= '0;
            tx_bit   <= '0;
        end else if (tick) begin
            tx_sub <= tx_sub + 4'd1;
            if (tx_busy) begin
                tx_line <= tx_frame[0];
                if (tx_sub == 4'(OS - 1)) begin
                    tx_frame <= {1'b1, tx_frame[9:1]};
                    tx_bit   <= tx_bit + 4'd1;
                    if (tx_bit == 4'd9) begin
                        tx_busy <= 1'b0;
                    end
                end
            end else begin
                tx_line <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            transmit_ready_output <= 1'b1;
        end else begin
            transmit_ready_output <= !tx_hold_full && !tx_busy; // [RQ9]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            host_view.line_status_word      <= '0;
            host_view.interrupt_source_word <= `UET_IIR_NONE_CODE;
            irq                             <= 1'b0;
        end else begin
            host_view.line_status_word <=
                {1'b0, !tx_hold_full && !tx_busy, !tx_hold_full,
                 4'h0, data_ready};
            host_view.interrupt_source_word <= rx_int ? `UET_IIR_RX_CODE
                : tx_int ? `UET_IIR_TX_CODE : `UET_IIR_NONE_CODE;
            irq <= rx_int;
        end
    end

    AST_RX_IRQ: assert property (@(posedge clk) disable iff (srst) // [RQ6]
        stop_done |=> rx_int)
        else $error("receive interrupt missing after stop");
    AST_RX_READY: assert property (@(posedge clk) disable iff (srst) // [RQ8]
        stop_done |=> receive_ready_output)
        else $error("receive ready late");
    AST_READ_CLR: assert property (@(posedge clk) disable iff (srst) // [RQ10]
        host_req.rd_rx && !stop_done |=> !rx_int && !receive_ready_output)
        else $error("read did not clear");
    AST_FIFO_DATA: assert property (@(posedge clk) disable iff (srst) // [RQ4]
        stop_done && fifo_mode |=> host_view.receive_holding_word
                                   == $past(rx_shift))
        else $error("fifo data lags status");
    AST_LOAD_BOUND: assert property (@(posedge clk) disable iff (srst) // [RQ2]
        stop_done && !fifo_mode |=> rx_state == UET_RX_LOAD)
        else $error("holding load not scheduled");
    AST_TX_IDLE: assert property (@(posedge clk) disable iff (srst) // [RQ9]
        tx_busy |=> !transmit_ready_output)
        else $error("transmit ready high while sending");
    AST_TX_WAIT: assert property (@(posedge clk) disable iff (srst) // [RQ7]
        host_req.wr_tx && tx_int_first && !tx_hold_full
        |=> tx_wait == 5'(`UET_TX_START_WAIT))
        else $error("start delay not loaded");
    AST_TX_RANGE: assert property (@(posedge clk) disable iff (srst) // [RQ7]
        tx_wait <= 5'(`UET_TX_START_MAX) && (tx_int_first ||
        5'(`UET_TX_START_WAIT) >= 5'(`UET_TX_START_MIN)))
        else $error("start delay out of range");
    CV_RX: cover property (@(posedge clk) stop_done);
    CV_TX: cover property (@(posedge clk) !tx_busy ##1 tx_busy);
    CV_RD: cover property (@(posedge clk) rx_int ##1 host_req.rd_rx);
endmodule

//--- uet_host_model.sv
`timescale 1ns/100ps
module uet_host_model
    import uet_pkg::*;
(
    input  wire logic           clk,
    input  wire logic [15:0]    divisor,
    input  wire uet_host_view_t host_view,
    output uet_host_req_t       host_req
);
    initial host_req = '0;
    // Released bus carries inverted data, never the last value
    task automatic put(input logic rd, input logic wr, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge clk);
        #1;
        host_req = {rd, wr, d};
        @(posedge clk);
        q = host_view.receive_holding_word;
        #1;
        host_req = {2'b00, ~d};
    endtask
    task automatic read_rx(input logic fifo, output logic [7:0] q);
        while (host_view.line_status_word[0] !== 1'b1) @(posedge clk);
        // Holding word may lag status by one baud tick
        if (!fifo) repeat (divisor) @(posedge clk);
        put(1'b1, 1'b0, 8'h00, q);
    endtask
endmodule

//--- testbench.sv
`timescale 1ns/100ps
`include "uet_consts.svh"
module testbench import uet_pkg::*;;
    localparam int DIV = 3;
    localparam int BIT = 16 * DIV;
    typedef struct packed {
        logic       fifo;
        logic [7:0] data;
    } uet_row_t;
    logic           clk = 1'b0;
    logic           srst = 1'b1;
    logic           fifo_mode = 1'b0;
    logic           rx_line = 1'b1;
    logic [15:0]    divisor = 16'h0003;
    uet_host_req_t  host_req;
    uet_host_view_t host_view;
    logic           irq;
    logic           rx_rdy;
    logic           tx_rdy;
    logic           tx_line;
    int             err_total = 0;
    int             n_compared = 0;
    int             cycles = 0;
    int             n;
    logic [7:0]     q;
    logic [7:0]     q2;
    uet_row_t       rows [4] = '{'{1'b0, 8'hA5}, '{1'b1, 8'h3C},
                                 '{1'b0, 8'h80}, '{1'b1, 8'h01}};
    uet_channel i_dut (
        .clk                   (clk),
        .srst                  (srst),
        .divisor               (divisor),
        .fifo_mode             (fifo_mode),
        .host_req              (host_req),
        .rx_line               (rx_line),
        .host_view             (host_view),
        .irq                   (irq),
        .receive_ready_output  (rx_rdy),
        .transmit_ready_output (tx_rdy),
        .tx_line               (tx_line)
    );
    uet_host_model i_host (
        .clk       (clk),
        .divisor   (divisor),
        .host_view (host_view),
        .host_req  (host_req)
    );
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (err_total == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_reset();
        srst = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        srst = 1'b0;
        check({irq, rx_rdy, tx_rdy, tx_line, host_view.interrupt_source_word},
              8'h31);
        check(host_view.receive_holding_word, 8'h00);
    endtask
    // Returns at the start of the stop bit
    task automatic send_rx(input logic [7:0] d);
        logic [8:0] f;
        f = {d, 1'b0};
        for (int i = 0; i < 9; i++) begin
            rx_line = f[i];
            repeat (BIT) @(posedge clk);
            #1;
        end
        rx_line = 1'b1;
    endtask
    task automatic get_tx(output logic [7:0] d, output int c);
        // Last data bit of the previous frame may be low
        c = 0;
        while (tx_line !== 1'b1 && c < BIT) begin
            @(negedge clk);
            c++;
        end
        c = 0;
        while (tx_line !== 1'b0 && c < 30 * BIT) begin
            @(negedge clk);
            c++;
        end
        repeat (BIT / 2) @(negedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(negedge clk);
            d[i] = tx_line;
        end
    endtask
    initial begin
        chk_reset();
        foreach (rows[k]) begin
            fifo_mode = rows[k].fifo;
            send_rx(rows[k].data);
            n = 0;
            // Stop bit itself, then one bit period of grace
            while (irq !== 1'b1 && n < 2 * BIT) begin
                @(posedge clk);
                #1;
                n++;
            end
            check({7'h00, irq}, 8'h01);
            check({7'h00, rx_rdy}, 8'h01);
            @(posedge clk);
            #1;
            check({host_view.line_status_word[0], 3'h0,
                   host_view.interrupt_source_word},
                  {1'b1, 3'h0, `UET_IIR_RX_CODE});
            if (rows[k].fifo) begin
                check(host_view.receive_holding_word, rows[k].data);
            end
            i_host.read_rx(rows[k].fifo, q);
            check(q, rows[k].data);
            repeat (2) @(posedge clk);
            #1;
            check({6'h00, irq, rx_rdy}, 8'h00);
            repeat (BIT) @(posedge clk);
            #1;
        end
        // Second write lands while the first is on the line; the third finds the holding word full and is dropped
        fork
            get_tx(q, n);
            begin
                i_host.put(1'b0, 1'b1, 8'hC3, q2);
                wait (tx_line === 1'b0);
                i_host.put(1'b0, 1'b1, 8'h5A, q2);
                i_host.put(1'b0, 1'b1, 8'hFF, q2);
                repeat (16 * DIV - 5) @(posedge clk);
                #1;
                check({7'h00, tx_rdy}, 8'h00);
            end
        join
        check({7'h00, n >= `UET_TX_START_MIN * BIT &&
               n <= `UET_TX_START_MAX * BIT + 2}, 8'h01);
        check(q, 8'hC3);
        get_tx(q, n);
        check(q, 8'h5A);
        get_tx(q, n);
        check({7'h00, n == 30 * BIT}, 8'h01);
        // Both transmit stages empty, only the transmit source pending
        check(host_view.line_status_word, 8'h60);
        check({4'h0, host_view.interrupt_source_word},
              {4'h0, `UET_IIR_TX_CODE});
        @(posedge clk);
        #1;
        fifo_mode = 1'b0;
        send_rx(8'h77);
        chk_reset();
        stop_test();
    end
endmodule
